// [shared/tvs_pkg.sv]
// Purpose: Constants for the temperature value and source select register bank.
// Assumes: Byte-wide register port with eight-bit addresses.
// Notes: Offsets are the printed byte addresses.
`default_nettype none
package tvs_pkg;
    localparam logic [7:0] ADDR_Z2A_F_HIGH = 8'h1d;
    localparam logic [7:0] ADDR_Z2B_F_LOW = 8'h1e;
    localparam logic [7:0] ADDR_Z2B_F_HIGH = 8'h1f;
    localparam logic [7:0] ADDR_Z3_LOW = 8'h20;
    localparam logic [7:0] ADDR_Z3_HIGH = 8'h21;
    localparam logic [7:0] ADDR_Z4_LOW = 8'h22;
    localparam logic [7:0] ADDR_Z4_HIGH = 8'h23;
    localparam logic [7:0] ADDR_SRC_SEL = 8'h31;
    localparam logic [7:0] SRC_SEL_RESET = 8'h00;
    localparam logic [7:0] SRC_SEL_MASK = 8'h1f;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] HALF_LOW_MASK = 8'h80;
    localparam logic [7:0] FRAC_LOW_MASK = 8'hf0;
    localparam logic [7:0] SIGN_FLIP = 8'h80;
    localparam int BIT_CH11 = 0;
    localparam int BIT_CH15 = 1;
    localparam int BIT_R1B = 2;
    localparam int BIT_R2B = 3;
    localparam int BIT_HOST_Z3 = 4;
endpackage : tvs_pkg
`default_nettype wire

// [verilog/tvs_regs.sv]
// Purpose: Zone temperature value registers and the temperature source select register.
// Assumes: Single clock; the register port is a simple byte strobe interface.
// Notes: Converter results arrive on the same clock together with a load strobe.
//
// Behaviour
// - The zone 2a filtered high byte reads the same value as the zone 2a filtered register.
// - Zone 2b filtered pair is read only, high mirrors its source, low keeps bits 7 to 4.
// - Zone 3 and 4 use a signed high byte and a low byte with only the half degree bit.
// - The zone 3 high byte is the internal temperature register itself.
// - The zone 4 high byte is the external digital temperature register itself.
// - With bit 0 set and bit 4 clear, zone 3 loads channel eleven with its top bit inverted.
// - With bits 0 and 4 clear, zone 3 loads the on-chip diode reading.
// - All zone 3 and 4 consumers see the value of the selected source.
// - With bit 1 set, zone 4 is read only and loads channel fifteen with top bit inverted.
// - With bit 1 clear, zone 4 takes host writes and host keeps it current.
// - Bit 2 selects remote diode 1b over analog input one on a shared pin.
// - Bit 3 selects remote diode 2b over analog input two on a shared pin.
// - With bit 4 set, zone 3 stops automatic loads and takes host writes.
`default_nettype none
module tvs_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // Values from the measurement side
    input wire logic [7:0] i_zone2a_filtered,
    input wire logic [7:0] i_zone2b_filtered_high,
    input wire logic [7:0] i_zone2b_filtered_low,
    input wire logic [7:0] i_diode_high,
    input wire logic i_diode_half,
    input wire logic i_diode_load,
    input wire logic [7:0] i_analog_channel_eleven,
    input wire logic i_ch11_load,
    input wire logic [7:0] i_analog_channel_fifteen,
    input wire logic i_ch15_load,
    // Values to consumers
    output logic [7:0] o_zone3_temp,
    output logic o_zone3_half,
    output logic [7:0] o_zone4_temp,
    output logic o_zone4_half,
    // Pin function selects
    output logic o_remote_one_b_pin_select,
    output logic o_remote_two_b_pin_select
);
    // Source select register.
    logic [7:0] src_sel_r;
    logic [7:0] src_sel_nxt;

    // Zone 3 store: whole degrees and the half degree bit.
    logic [7:0] z3_high_r;
    logic [7:0] z3_high_nxt;
    logic z3_half_r;
    logic z3_half_nxt;

    // Zone 4 store: whole degrees and the half degree bit.
    logic [7:0] z4_high_r;
    logic [7:0] z4_high_nxt;
    logic z4_half_r;
    logic z4_half_nxt;

    // Select fields, one named wire per bit.
    wire internal_from_channel_eleven = src_sel_r[tvs_pkg::BIT_CH11];
    wire external_from_channel_fifteen = src_sel_r[tvs_pkg::BIT_CH15];
    wire remote_one_b_sel = src_sel_r[tvs_pkg::BIT_R1B];
    wire remote_two_b_sel = src_sel_r[tvs_pkg::BIT_R2B];
    wire host_z3 = src_sel_r[tvs_pkg::BIT_HOST_Z3];

    // Address decode for the read path; the zone 3, zone 4 and select hits also drive the write strobes.
    wire hit_z2a_high = (i_addr == tvs_pkg::ADDR_Z2A_F_HIGH);
    wire hit_z2b_low = (i_addr == tvs_pkg::ADDR_Z2B_F_LOW);
    wire hit_z2b_high = (i_addr == tvs_pkg::ADDR_Z2B_F_HIGH);

    wire hit_z3_low = (i_addr == tvs_pkg::ADDR_Z3_LOW);
    wire hit_z3_high = (i_addr == tvs_pkg::ADDR_Z3_HIGH);

    wire hit_z4_low = (i_addr == tvs_pkg::ADDR_Z4_LOW);
    wire hit_z4_high = (i_addr == tvs_pkg::ADDR_Z4_HIGH);

    wire hit_sel = (i_addr == tvs_pkg::ADDR_SRC_SEL);

    // The mirrored filtered bytes get no strobe, so writes to them are dropped.
    wire wr_sel = i_wr && hit_sel;

    wire wr_z3h = i_wr && hit_z3_high;
    wire wr_z3l = i_wr && hit_z3_low;

    wire wr_z4h = i_wr && hit_z4_high;
    wire wr_z4l = i_wr && hit_z4_low;

    wire wdata_half = |(i_wdata & tvs_pkg::HALF_LOW_MASK);

    // reserved bits dropped
    // Masking on the way in keeps the read path free of a second mask.
    always_comb begin
        src_sel_nxt = src_sel_r;
        if (wr_sel) begin
            src_sel_nxt = i_wdata & tvs_pkg::SRC_SEL_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            src_sel_r <= tvs_pkg::SRC_SEL_RESET;
        end else begin
            src_sel_r <= src_sel_nxt;
        end
    end

    // Converter codes are offset binary; flipping the top bit makes them signed.
    wire [7:0] ch11_signed = i_analog_channel_eleven ^ tvs_pkg::SIGN_FLIP;
    wire [7:0] ch15_signed = i_analog_channel_fifteen ^ tvs_pkg::SIGN_FLIP;

    // Which producer owns zone 3 this cycle.
    typedef enum {
        TVS_Z3_DIODE,
        TVS_Z3_CH11,
        TVS_Z3_HOST
    } tvs_z3_src_e;

    tvs_z3_src_e z3_src;

    // host owns zone 3
    // Host mode is checked first, so no automatic load can race a host write.
    always_comb begin
        if (host_z3) begin
            z3_src = TVS_Z3_HOST;
        end else if (internal_from_channel_eleven) begin
            z3_src = TVS_Z3_CH11;
        end else begin
            z3_src = TVS_Z3_DIODE;
        end
    end

    always_comb begin
        z3_high_nxt = z3_high_r;
        case (z3_src)
            TVS_Z3_CH11: begin
                if (i_ch11_load) begin
                    z3_high_nxt = ch11_signed;
                end
            end
            TVS_Z3_DIODE: begin
                if (i_diode_load) begin
                    z3_high_nxt = i_diode_high;
                end
            end
            TVS_Z3_HOST: begin
                if (wr_z3h) begin
                    z3_high_nxt = i_wdata;
                end
            end
            default: begin
                z3_high_nxt = z3_high_r;
            end
        endcase
    end

    // A channel source carries no fraction, so its load clears the half bit.
    always_comb begin
        z3_half_nxt = z3_half_r;
        case (z3_src)
            TVS_Z3_CH11: begin
                if (i_ch11_load) begin
                    z3_half_nxt = 1'b0;
                end
            end
            TVS_Z3_DIODE: begin
                if (i_diode_load) begin
                    z3_half_nxt = i_diode_half;
                end
            end
            TVS_Z3_HOST: begin
                if (wr_z3l) begin
                    z3_half_nxt = wdata_half;
                end
            end
            default: begin
                z3_half_nxt = z3_half_r;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            z3_high_r <= tvs_pkg::TEMP_RESET;
        end else begin
            z3_high_r <= z3_high_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            z3_half_r <= 1'b0;
        end else begin
            z3_half_r <= z3_half_nxt;
        end
    end

    // Which producer owns zone 4 this cycle.
    typedef enum {
        TVS_Z4_HOST,
        TVS_Z4_CH15
    } tvs_z4_src_e;

    tvs_z4_src_e z4_src;

    always_comb begin
        if (external_from_channel_fifteen) begin
            z4_src = TVS_Z4_CH15;
        end else begin
            z4_src = TVS_Z4_HOST;
        end
    end

    // A converter that never strobes leaves zone 4 holding its last value.
    always_comb begin
        z4_high_nxt = z4_high_r;
        case (z4_src)
            TVS_Z4_CH15: begin
                if (i_ch15_load) begin
                    z4_high_nxt = ch15_signed;
                end
            end
            TVS_Z4_HOST: begin
                if (wr_z4h) begin
                    z4_high_nxt = i_wdata;
                end
            end
            default: begin
                z4_high_nxt = z4_high_r;
            end
        endcase
    end

    always_comb begin
        z4_half_nxt = z4_half_r;
        case (z4_src)
            TVS_Z4_CH15: begin
                if (i_ch15_load) begin
                    z4_half_nxt = 1'b0;
                end
            end
            TVS_Z4_HOST: begin
                if (wr_z4l) begin
                    z4_half_nxt = wdata_half;
                end
            end
            default: begin
                z4_half_nxt = z4_half_r;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            z4_high_r <= tvs_pkg::TEMP_RESET;
        end else begin
            z4_high_r <= z4_high_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            z4_half_r <= 1'b0;
        end else begin
            z4_half_r <= z4_half_nxt;
        end
    end

    wire [7:0] z3_low = {8{z3_half_r}} & tvs_pkg::HALF_LOW_MASK;
    wire [7:0] z4_low = {8{z4_half_r}} & tvs_pkg::HALF_LOW_MASK;

    wire [7:0] z2b_low = i_zone2b_filtered_low & tvs_pkg::FRAC_LOW_MASK;

    // Read terms, each zero unless its own address is selected.
    // zone 2a mirror
    wire [7:0] rd_z2a_high = hit_z2a_high ? i_zone2a_filtered : 8'h00;

    wire [7:0] rd_z2b_low = hit_z2b_low ? z2b_low : 8'h00;
    wire [7:0] rd_z2b_high = hit_z2b_high ? i_zone2b_filtered_high : 8'h00;

    wire [7:0] rd_z3_low = hit_z3_low ? z3_low : 8'h00;
    wire [7:0] rd_z3_high = hit_z3_high ? z3_high_r : 8'h00;

    wire [7:0] rd_z4_low = hit_z4_low ? z4_low : 8'h00;
    wire [7:0] rd_z4_high = hit_z4_high ? z4_high_r : 8'h00;

    wire [7:0] rd_sel = hit_sel ? src_sel_r : 8'h00;

    // Unmapped addresses read zero because every term is zero there.
    assign o_rdata = rd_z2a_high |
        rd_z2b_low |
        rd_z2b_high |
        rd_z3_low |
        rd_z3_high |
        rd_z4_low |
        rd_z4_high |
        rd_sel;

    assign o_zone3_temp = z3_high_r;
    assign o_zone3_half = z3_half_r;
    assign o_zone4_temp = z4_high_r;
    assign o_zone4_half = z4_half_r;

    assign o_remote_one_b_pin_select = remote_one_b_sel;

    assign o_remote_two_b_pin_select = remote_two_b_sel;
endmodule : tvs_regs
`default_nettype wire

// [verification/tvs_regs_chk.sv]
// Purpose: Port assertions for the temperature register bank.
// Assumes: Select value is tracked here from bus writes.
// Notes: Reads are combinational, loads land one edge later.
`default_nettype none
module tvs_regs_chk (
    input wire logic i_clk, i_nrst, i_wr, i_diode_half, i_diode_load, i_ch11_load, i_ch15_load,
    input wire logic [7:0] i_addr, i_wdata, o_rdata, i_zone2a_filtered, i_zone2b_filtered_low,
    input wire logic [7:0] i_diode_high, i_analog_channel_eleven, i_analog_channel_fifteen,
    input wire logic [7:0] o_zone3_temp, o_zone4_temp,
    input wire logic o_zone3_half, o_remote_one_b_pin_select, o_remote_two_b_pin_select
);
    logic [4:0] sel_r;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    always_ff @(posedge i_clk or negedge i_nrst)
        if (!i_nrst) sel_r <= 5'h00;
        else if (i_wr && i_addr == 8'h31) sel_r <= i_wdata[4:0];
    sequence s_ch11; sel_r[0] && !sel_r[4] && i_ch11_load; endsequence
    sequence s_dio; !sel_r[0] && !sel_r[4] && i_diode_load; endsequence
    property p_a; i_addr == 8'h1d |-> o_rdata == i_zone2a_filtered; endproperty
    a_a: assert property (p_a) else $error("bad");
    property p_b; i_addr == 8'h1e |-> o_rdata == (i_zone2b_filtered_low & 8'hf0); endproperty
    a_b: assert property (p_b) else $error("bad");
    property p_c; i_addr == 8'h21 |-> o_rdata == o_zone3_temp; endproperty
    a_c: assert property (p_c) else $error("bad");
    property p_d; i_addr == 8'h23 |-> o_rdata == o_zone4_temp; endproperty
    a_d: assert property (p_d) else $error("bad");
    property p_e; s_ch11 |=> o_zone3_temp == ($past(i_analog_channel_eleven) ^ 8'h80); endproperty
    a_e: assert property (p_e) else $error("bad");
    property p_f; s_dio |=> o_zone3_half == $past(i_diode_half); endproperty
    a_f: assert property (p_f) else $error("bad");
    property p_g; sel_r[1] && i_ch15_load |=> o_zone4_temp == ($past(i_analog_channel_fifteen) ^ 8'h80); endproperty
    a_g: assert property (p_g) else $error("bad");
    property p_h; i_addr == 8'h31 |-> o_rdata == {3'h0, sel_r}; endproperty
    a_h: assert property (p_h) else $error("bad");
    property p_i; sel_r[4] && i_wr && i_addr == 8'h21 |=> o_zone3_temp == $past(i_wdata); endproperty
    a_i: assert property (p_i) else $error("zone 3 host write lost");
    property p_j; !sel_r[1] && i_wr && i_addr == 8'h23 |=> o_zone4_temp == $past(i_wdata); endproperty
    a_j: assert property (p_j) else $error("zone 4 host write lost");
    property p_k; o_remote_one_b_pin_select == sel_r[2]; endproperty
    a_k: assert property (p_k) else $error("remote 1b select wrong");
    property p_l; o_remote_two_b_pin_select == sel_r[3]; endproperty
    a_l: assert property (p_l) else $error("remote 2b select wrong");
endmodule : tvs_regs_chk
`default_nettype wire

// [verification/tb_temp_value_source_select.sv]
// Purpose: Directed bench for the temperature register bank.
// Assumes: Inputs change on the falling edge.
// Notes: Loads are driven as one vector to keep stimulus short.
`default_nettype none
module tb_temp_value_source_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_nrst = 0, i_wr = 0, hf = 0, p1, p2, h3, h4;
    logic [2:0] ld = 0;
    logic [7:0] i_addr = 0, i_wdata = 0, za = 0, zh = 0, zl = 0, dh = 0, c11 = 0, c15 = 0;
    logic [7:0] o_rdata, z3, z4;
    int mismatches = 0, cmp_count = 0;
    always #12.5 i_clk = ~i_clk;
    tvs_regs dut (.i_clk, .i_nrst, .i_wr, .i_addr, .i_wdata, .o_rdata, .i_zone2a_filtered(za),
        .i_zone2b_filtered_high(zh), .i_zone2b_filtered_low(zl), .i_diode_high(dh),
        .i_diode_half(hf), .i_diode_load(ld[0]), .i_analog_channel_eleven(c11),
        .i_ch11_load(ld[1]), .i_analog_channel_fifteen(c15), .i_ch15_load(ld[2]),
        .o_zone3_temp(z3), .o_zone3_half(h3), .o_zone4_temp(z4), .o_zone4_half(h4),
        .o_remote_one_b_pin_select(p1), .o_remote_two_b_pin_select(p2));
    task chk(input logic [7:0] g, e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, d);
        @(negedge i_clk);
        i_wr = 1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 0;
    endtask : wr
    task rd(input logic [7:0] a, e);
        @(negedge i_clk);
        i_addr = a;
        #1 chk(o_rdata, e);
    endtask : rd
    task pl(input logic [2:0] m);
        @(negedge i_clk);
        ld = m;
        @(negedge i_clk);
        ld = 0;
    endtask : pl
    task t_sel;
        for (int a = 8'h1d; a < 8'h42; a++) rd(a[7:0], 8'h00);
        wr(8'h31, 8'hff);
        rd(8'h31, 8'h1f);
        chk({6'h0, p2, p1}, 8'h03);
    endtask : t_sel
    task t_z3;
        wr(8'h31, 8'h00);
        dh = 8'h5a;
        hf = 1;
        pl(3'h1);
        rd(8'h21, 8'h5a);
        rd(8'h20, 8'h80);
        chk({7'h0, h3}, 8'h01);
        wr(8'h31, 8'h01);
        c11 = 8'h90;
        pl(3'h3);
        chk(z3, 8'h10);
        wr(8'h21, 8'h33);
        rd(8'h21, 8'h10);
        wr(8'h31, 8'h10);
        wr(8'h21, 8'h33);
        pl(3'h3);
        rd(8'h21, 8'h33);
    endtask : t_z3
    task t_z4;
        wr(8'h31, 8'h00);
        chk({6'h0, p2, p1}, 8'h00);
        wr(8'h23, 8'hc4);
        wr(8'h22, 8'hff);
        rd(8'h22, 8'h80);
        chk(z4, 8'hc4);
        chk({7'h0, h4}, 8'h01);
        wr(8'h31, 8'h02);
        wr(8'h23, 8'h11);
        rd(8'h23, 8'hc4);
        c15 = 8'h05;
        pl(3'h4);
        rd(8'h23, 8'h85);
    endtask : t_z4
    task t_mir;
        za = 8'ha5;
        zh = 8'h3c;
        zl = 8'h5f;
        wr(8'h1f, 8'h00);
        rd(8'h1d, 8'ha5);
        rd(8'h1f, 8'h3c);
        rd(8'h1e, 8'h50);
    endtask : t_mir
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(negedge i_clk);
        i_nrst = 1;
        t_sel();
        t_z3();
        t_z4();
        t_mir();
        end_of_test();
    end
    initial begin
        #100us;
        mismatches++;
        end_of_test();
    end
endmodule : tb_temp_value_source_select
bind tvs_regs tvs_regs_chk u_chk (.*);
`default_nettype wire
